//--- gt_defines.svh
`ifndef GT_DEFINES_SVH
`define GT_DEFINES_SVH

`define GT_A_CTRL 8'h00
`define GT_A_GCTL 8'h04
`define GT_A_CLKS 8'h08
`define GT_A_CNTL 8'h0C
`define GT_A_CNTH 8'h10
`define GT_A_CMP 8'h14
`define GT_A_CAP 8'h18
`define GT_A_CCPM 8'h1C
`define GT_A_IRQC 8'h20

`define GT_ON 0
`define GT_WIDE_ACCESS_MODE 1
`define GT_SYNC 2
`define GT_CKPS 5:4
`define GT_CTRL_WMASK 8'h37
`define GT_GE 7
`define GT_GATE_POLARITY 6
`define GT_GTM 5
`define GT_GATE_SINGLE_PULSE_MODE 4
`define GT_GO 3
`define GT_GCTL_WMASK 8'hF8
`define GT_CAP_EN 0
`define GT_CMP_EN 1
`define GT_ADT_EN 2
`define GT_OVF_F 0
`define GT_GATE_F 1
`define GT_OVF_IE 2
`define GT_PERIPHERAL_IRQ_ENABLE 3
`define GT_GIE 4
`define GT_OSC_EN 5

`define GT_CS_FOSC4 4'h1
`define GT_CS_FOSC 4'h2
`define GT_CS_RES0 4'hE
`define GT_CS_RES1 4'hF
`define GT_FOSC4_LAST 2'h3
`define GT_CNT_MAX 16'hFFFF
`endif

//--- gt_pkg.sv
package gt_pkg;

  typedef enum logic [1:0] {
    GT_IDLE = 2'b00,
    GT_WR = 2'b01,
    GT_RDW = 2'b11,
    GT_RDD = 2'b10
  } gt_bus_t;

  typedef enum logic [3:0] {
    GT_R_CTRL, GT_R_GCTL, GT_R_CLKS, GT_R_CNTL, GT_R_CNTH,
    GT_R_CMP, GT_R_CAP, GT_R_CCPM, GT_R_IRQC, GT_R_NONE
  } gt_reg_t;

  typedef struct packed {
    gt_bus_t bus;
    logic [7:0] addr;
    logic [31:0] rdata;
    logic [7:0] ctrl;
    logic [7:0] gctl;
    logic [7:0] clks;
    logic [7:0] irqc;
    logic [2:0] ccpm;
    logic [15:0] cnt;
    logic [15:0] cmpv;
    logic [15:0] capv;
    logic [7:0] hbuf;
    logic [2:0] psc;
    logic [1:0] idiv;
    logic [16:0] s1;
    logic [16:0] s2;
    logic [16:0] s3;
    logic [16:0] lvl;
    logic tff;
    logic armed;
    logic polq;
    logic gvq;
    logic cmpm;
    logic cmp_ev;
    logic wake;
  } gt_state_t;

endpackage

//--- gt_timer16.sv
// Our own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "gt_defines.svh"

module gt_timer16 (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [15:0] clk_src,
  input wire logic gate_in,
  input wire logic sleep_active,
  input wire logic capture_evt,
  output logic irq_req,
  output logic wake_req,
  output logic cmp_event,
  output logic secondary_oscillator_run_req
);
  import gt_pkg::*;

  gt_state_t state_reg;
  gt_state_t state_next;
  logic [16:0] rise;
  logic take;
  logic wr;
  gt_reg_t widx;
  logic cwr_lo;
  logic cwr_hi;
  logic on;
  logic gate_single_pulse_mode;
  logic pre;
  logic pol;
  logic gate_level_status;
  logic tick;
  logic run;
  logic inc_en;
  logic inc;
  logic ovf_set;
  logic match;
  logic [15:0] wd;

  // ----------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------
  function automatic gt_reg_t gt_dec(input logic [7:0] a);
    case (a)
      `GT_A_CTRL: gt_dec = GT_R_CTRL;
      `GT_A_GCTL: gt_dec = GT_R_GCTL;
      `GT_A_CLKS: gt_dec = GT_R_CLKS;
      `GT_A_CNTL: gt_dec = GT_R_CNTL;
      `GT_A_CNTH: gt_dec = GT_R_CNTH;
      `GT_A_CMP: gt_dec = GT_R_CMP;
      `GT_A_CAP: gt_dec = GT_R_CAP;
      `GT_A_CCPM: gt_dec = GT_R_CCPM;
      `GT_A_IRQC: gt_dec = GT_R_IRQC;
      default: gt_dec = GT_R_NONE;
    endcase
  endfunction

  function automatic logic [2:0] gt_pmask(input logic [1:0] ps);
    case (ps)
      2'h0: gt_pmask = 3'h0;
      2'h1: gt_pmask = 3'h1;
      2'h2: gt_pmask = 3'h3;
      default: gt_pmask = 3'h7;
    endcase
  endfunction

  // ----------------------------------------------------------
  // Next state
  // ----------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    wd = hwdata[15:0];
    // Three-stage input filter; a level counts once stages 2 and 3 agree.
    state_next.s1 = {gate_in, clk_src};
    state_next.s2 = state_reg.s1;
    state_next.s3 = state_reg.s2;
    state_next.lvl = (~(state_reg.s2 ^ state_reg.s3) & state_reg.s3) |
                     ((state_reg.s2 ^ state_reg.s3) & state_reg.lvl);
    rise = state_next.lvl & ~state_reg.lvl;
    state_next.idiv = state_reg.idiv + 2'h1;

    // Bus slave: writes act in the data phase, reads take one wait state.
    take = hsel && htrans[1] && hready;
    wr = (state_reg.bus == GT_WR);
    widx = wr ? gt_dec(state_reg.addr) : GT_R_NONE;
    cwr_lo = (widx == GT_R_CNTL);
    cwr_hi = (widx == GT_R_CNTH);
    case (state_reg.bus)
      GT_RDW: begin
        state_next.bus = GT_RDD;
      end
      default: begin
        if (take) begin
          state_next.bus = hwrite ? GT_WR : GT_RDW;
          state_next.addr = haddr[7:0];
        end else begin
          state_next.bus = GT_IDLE;
        end
      end
    endcase

    // Gate chain.
    on = state_reg.ctrl[`GT_ON];
    if (!on || !state_reg.gctl[`GT_GTM]) begin
      state_next.tff = 1'b0;
    end else if (rise[16]) begin
      state_next.tff = ~state_reg.tff;
    end
    pre = state_reg.gctl[`GT_GTM] ? state_reg.tff : state_reg.lvl[16];
    pol = state_reg.gctl[`GT_GATE_POLARITY] ? pre : ~pre;
    state_next.polq = pol;
    gate_single_pulse_mode = state_reg.gctl[`GT_GATE_SINGLE_PULSE_MODE];
    gate_level_status = gate_single_pulse_mode ? (pol && state_reg.armed) : pol;
    state_next.gvq = gate_level_status;
    if (!gate_single_pulse_mode) begin
      state_next.armed = 1'b0;
    end else if (state_reg.armed && !pol && state_reg.polq) begin
      state_next.armed = 1'b0;
      state_next.gctl[`GT_GO] = 1'b0;
    end else if (state_reg.gctl[`GT_GO] && pol && !state_reg.polq) begin
      state_next.armed = 1'b1;
    end

    // Clock source select and sleep gating.
    case (state_reg.clks[3:0])
      `GT_CS_FOSC4: tick = (state_reg.idiv == `GT_FOSC4_LAST);
      `GT_CS_FOSC: tick = 1'b1;
      `GT_CS_RES0, `GT_CS_RES1: tick = 1'b0;
      default: tick = rise[state_reg.clks[3:0]];
    endcase
    // The sync bit only matters for external sources.
    run = !sleep_active || (state_reg.ctrl[`GT_SYNC] &&
          state_reg.clks[3:0] != `GT_CS_FOSC &&
          state_reg.clks[3:0] != `GT_CS_FOSC4);
    inc_en = on && run && tick &&
             (!state_reg.gctl[`GT_GE] || gate_level_status);

    // Prescaler.
    inc = 1'b0;
    if (inc_en) begin
      if ((state_reg.psc | ~gt_pmask(state_reg.ctrl[`GT_CKPS])) == 3'h7) begin
        state_next.psc = 3'h0;
        inc = 1'b1;
      end else begin
        state_next.psc = state_reg.psc + 3'h1;
      end
    end
    if (cwr_lo) begin
      state_next.psc = 3'h0;
    end

    // Counter, with software write above the trigger clear above counting.
    ovf_set = inc && (state_reg.cnt == `GT_CNT_MAX);
    if (inc) begin
      state_next.cnt = state_reg.cnt + 16'h1;
    end
    if (state_reg.ccpm[`GT_ADT_EN] && state_reg.cmp_ev) begin
      state_next.cnt = 16'h0;
    end
    if (cwr_lo) begin
      if (state_reg.ctrl[`GT_WIDE_ACCESS_MODE]) begin
        state_next.cnt = {state_reg.hbuf, wd[7:0]};
      end else begin
        state_next.cnt[7:0] = wd[7:0];
      end
    end
    if (cwr_hi) begin
      if (state_reg.ctrl[`GT_WIDE_ACCESS_MODE]) begin
        state_next.hbuf = wd[7:0];
      end else begin
        state_next.cnt[15:8] = wd[7:0];
      end
    end

    // Compare and capture.
    match = state_reg.ccpm[`GT_CMP_EN] && (state_reg.cnt == state_reg.cmpv);
    state_next.cmpm = match;
    state_next.cmp_ev = match && !state_reg.cmpm;
    if (state_reg.ccpm[`GT_CAP_EN] && capture_evt) begin
      state_next.capv = state_reg.cnt;
    end

    // Remaining register writes.
    case (widx)
      GT_R_CTRL: state_next.ctrl = wd[7:0] & `GT_CTRL_WMASK;
      GT_R_GCTL: state_next.gctl = wd[7:0] & `GT_GCTL_WMASK;
      GT_R_CLKS: state_next.clks = {4'h0, wd[3:0]};
      GT_R_CMP: state_next.cmpv = wd;
      GT_R_CCPM: state_next.ccpm = wd[2:0];
      GT_R_IRQC: state_next.irqc = {2'h0, wd[5:0]};
      default: state_next.irqc = state_next.irqc;
    endcase
    if (!state_next.gctl[`GT_GATE_SINGLE_PULSE_MODE]) begin
      state_next.gctl[`GT_GO] = 1'b0;
    end
    // Hardware sets win over a software clear in the same cycle.
    if (ovf_set) begin
      state_next.irqc[`GT_OVF_F] = 1'b1;
    end
    if (state_reg.gvq && !gate_level_status) begin
      state_next.irqc[`GT_GATE_F] = 1'b1;
    end
    state_next.wake = sleep_active && ovf_set && on &&
                      state_reg.irqc[`GT_OVF_IE] &&
                      state_reg.irqc[`GT_PERIPHERAL_IRQ_ENABLE];

    // Read data is formed in the wait cycle.
    if (state_reg.bus == GT_RDW) begin
      case (gt_dec(state_reg.addr))
        GT_R_CTRL: state_next.rdata = {24'h0, state_reg.ctrl};
        GT_R_GCTL: state_next.rdata = {24'h0, state_reg.gctl[7:3],
                                       gate_level_status, 2'h0};
        GT_R_CLKS: state_next.rdata = {24'h0, state_reg.clks};
        GT_R_CNTL: begin
          state_next.rdata = {24'h0, state_reg.cnt[7:0]};
          if (state_reg.ctrl[`GT_WIDE_ACCESS_MODE]) begin
            state_next.hbuf = state_reg.cnt[15:8];
          end
        end
        GT_R_CNTH: state_next.rdata = {24'h0, state_reg.ctrl[`GT_WIDE_ACCESS_MODE] ?
                                       state_reg.hbuf : state_reg.cnt[15:8]};
        GT_R_CMP: state_next.rdata = {16'h0, state_reg.cmpv};
        GT_R_CAP: state_next.rdata = {16'h0, state_reg.capv};
        GT_R_CCPM: state_next.rdata = {29'h0, state_reg.ccpm};
        GT_R_IRQC: state_next.rdata = {24'h0, state_reg.irqc};
        default: state_next.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------
  assign hrdata = state_reg.rdata;
  assign hreadyout = (state_reg.bus != GT_RDW);
  assign hresp = 1'b0;
  assign irq_req = state_reg.irqc[`GT_OVF_F] && on &&
                   state_reg.irqc[`GT_OVF_IE] && state_reg.irqc[`GT_PERIPHERAL_IRQ_ENABLE] &&
                   state_reg.irqc[`GT_GIE];
  assign wake_req = state_reg.wake;
  assign cmp_event = state_reg.cmp_ev;
  // The oscillator request ignores sleep and the sync bit.
  assign secondary_oscillator_run_req = state_reg.irqc[`GT_OSC_EN];

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_rd_wait;
    !hreadyout ##1 hreadyout;
  endsequence

  chk_bus_read: assert property (
    (take && !hwrite && hreadyout) |=> s_rd_wait)
    else $error("read answer not after one wait state");

  chk_ovf_wrap: assert property (
    (inc && state_reg.cnt == 16'hFFFF && !cwr_lo && !cwr_hi &&
     !(state_reg.ccpm[`GT_ADT_EN] && state_reg.cmp_ev))
    |=> state_reg.cnt == 16'h0 && state_reg.irqc[`GT_OVF_F])
    else $error("overflow wrap or flag wrong");

  chk_irq_gate: assert property (
    irq_req |-> state_reg.ctrl[`GT_ON] && state_reg.irqc[`GT_GIE])
    else $error("interrupt raised without enables");

  chk_flag_sticky: assert property (
    (state_reg.irqc[`GT_OVF_F] && widx != GT_R_IRQC)
    |=> state_reg.irqc[`GT_OVF_F])
    else $error("overflow flag dropped by itself");

  chk_sleep_hold: assert property (
    (sleep_active && !state_reg.ctrl[`GT_SYNC] && !cwr_lo && !cwr_hi &&
     !state_reg.cmp_ev) |=> $stable(state_reg.cnt))
    else $error("counter moved in synchronised sleep");

  chk_capture_copy: assert property (
    (state_reg.ccpm[`GT_CAP_EN] && capture_evt)
    |=> state_reg.capv == $past(state_reg.cnt))
    else $error("capture value wrong");

  chk_trig_clear: assert property (
    (state_reg.ccpm[`GT_ADT_EN] && state_reg.cmp_ev && !cwr_lo && !cwr_hi
     && !inc && widx != GT_R_IRQC)
    |=> state_reg.cnt == 16'h0 && $stable(state_reg.irqc[`GT_OVF_F]))
    else $error("trigger clear wrong");

  chk_write_wins: assert property (
    (cwr_lo && !state_reg.ctrl[`GT_WIDE_ACCESS_MODE] && state_reg.cmp_ev &&
     state_reg.ccpm[`GT_ADT_EN]) |=> state_reg.cnt[7:0] == $past(wd[7:0]))
    else $error("trigger clear beat a counter write");

  chk_off_hold: assert property (
    (!on && !cwr_lo && !cwr_hi && !state_reg.cmp_ev)
    |=> $stable(state_reg.cnt) && !state_reg.tff)
    else $error("counter moved while off");

  chk_go_clear: assert property (
    !state_reg.gctl[`GT_GATE_SINGLE_PULSE_MODE] |-> !state_reg.gctl[`GT_GO])
    else $error("go bit set outside single pulse");

  chk_reserved_clk: assert property (
    (state_reg.clks[3:0] >= `GT_CS_RES0 && !cwr_lo && !cwr_hi &&
     !state_reg.cmp_ev) |=> $stable(state_reg.cnt))
    else $error("counter moved on reserved clock");

  sequence s_pulse_arm;
    gate_single_pulse_mode && state_reg.gctl[`GT_GO] && pol && !state_reg.polq;
  endsequence

  sequence s_pulse_trail;
    gate_single_pulse_mode && state_reg.armed && !pol && state_reg.polq && widx != GT_R_GCTL;
  endsequence

  chk_pulse_arm: assert property (
    s_pulse_arm |=> state_reg.armed)
    else $error("single pulse not armed by gate edge");

  chk_pulse_end: assert property (
    s_pulse_trail
    |=> !state_reg.armed && !state_reg.gctl[`GT_GO])
    else $error("single pulse did not end on trailing edge");

  chk_toggle_flip: assert property (
    (on && state_reg.gctl[`GT_GTM] && rise[16])
    |=> state_reg.tff != $past(state_reg.tff))
    else $error("toggle flip-flop missed a gate edge");

  chk_toggle_clear: assert property (
    !state_reg.gctl[`GT_GTM] |=> !state_reg.tff)
    else $error("toggle flip-flop not held clear");

  chk_gate_flag: assert property (
    (state_reg.gvq && !gate_level_status) |=> state_reg.irqc[`GT_GATE_F])
    else $error("gate event flag not set on falling gate level");

  chk_psc_clear: assert property (
    cwr_lo |=> state_reg.psc == 3'h0)
    else $error("prescaler not cleared by low byte write");

  chk_hbuf_load: assert property (
    (cwr_lo && state_reg.ctrl[`GT_WIDE_ACCESS_MODE])
    |=> state_reg.cnt[15:8] == $past(state_reg.hbuf))
    else $error("high byte not loaded from buffer");

  chk_wide_read: assert property (
    (state_reg.bus == GT_RDW && state_reg.addr == `GT_A_CNTL &&
     state_reg.ctrl[`GT_WIDE_ACCESS_MODE])
    |=> state_reg.hbuf == $past(state_reg.cnt[15:8]))
    else $error("high byte not latched by low byte read");

  chk_gate_hold: assert property (
    (state_reg.gctl[`GT_GE] && !gate_level_status && !cwr_lo && !cwr_hi &&
     !state_reg.cmp_ev) |=> $stable(state_reg.cnt))
    else $error("counter moved while gate inactive");

  chk_wake_flag: assert property (
    wake_req |-> $past(sleep_active) && state_reg.irqc[`GT_OVF_F])
    else $error("wake request without an overflow in sleep");

  chk_cmp_pulse: assert property (
    cmp_event |=> !cmp_event)
    else $error("compare event longer than one cycle");

  chk_gate_armed: assert property (
    (gate_single_pulse_mode && !state_reg.armed) |-> !gate_level_status)
    else $error("gate level shown while single pulse idle");

endmodule // gt_timer16

//--- gt_src_model.sv
`timescale 1ns/1ps

// ----------------------------------------
// Far-side clock sources and gate
// ----------------------------------------
// Every source ticks with a rising edge each 8 hclk, so edges stay well
// apart for the input filter; the sources stand low while not running.
module gt_src_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic run,
  input wire logic gate_lvl,
  output logic [15:0] clk_src,
  output logic gate_in
);
  logic [2:0] div_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_reg <= 3'h0;
    end else if (run) begin
      div_reg <= div_reg + 3'h1;
    end else begin
      div_reg <= 3'h0;
    end
  end

  assign clk_src = {16{div_reg[2]}};
  assign gate_in = gate_lvl;
endmodule // gt_src_model

//--- test_gated_16bit_timer_control.sv
`timescale 1ns/1ps
`include "gt_defines.svh"

module test_gated_16bit_timer_control;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, run, gate_lvl;
  logic sleep_active, capture_evt, irq_req, wake_req, cmp_event, gate_in;
  logic secondary_oscillator_run_req;
  logic [31:0] haddr, hwdata, hrdata, r, a;
  logic [1:0] htrans;
  logic [15:0] clk_src;
  logic [7:0] d;
  int n_fail, check_count, cyc, ncmp, nwake, t1, dt, p;

  gt_timer16 i_gt_timer16 (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .clk_src(clk_src),
    .gate_in(gate_in), .sleep_active(sleep_active),
    .capture_evt(capture_evt), .irq_req(irq_req), .wake_req(wake_req),
    .cmp_event(cmp_event), .secondary_oscillator_run_req(secondary_oscillator_run_req));

  gt_src_model i_gt_src_model (.hclk(hclk), .hresetn(hresetn), .run(run),
    .gate_lvl(gate_lvl), .clk_src(clk_src), .gate_in(gate_in));

  // ----------------------------------------
  // Clock, monitors and timeout
  // ----------------------------------------
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  always @(negedge hclk) begin
    cyc++;
    if (cmp_event === 1'b1) ncmp++;
    if (wake_req === 1'b1) nwake++;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end

  // ----------------------------------------
  // Bus access and checking
  // ----------------------------------------
  // Ready and read data are looked at on the falling edge, where they hold
  // the value that the next rising edge samples.
  task automatic bus(input logic w, input logic [7:0] ad,
                     input logic [31:0] wd, output logic [31:0] rd_q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, ad};
    hwrite <= w;
    htrans <= 2'h2;
    @(negedge hclk);
    while (hreadyout !== 1'b1) @(negedge hclk);
    @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(negedge hclk);
    while (hreadyout !== 1'b1) @(negedge hclk);
    rd_q = hrdata;
    @(posedge hclk);
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
    logic [31:0] x;
    bus(1'b1, ad, wd, x);
  endtask

  task automatic rd(input logic [7:0] ad, output logic [31:0] rd_q);
    bus(1'b0, ad, 32'h0, rd_q);
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Counter low-byte advance d between two reads around a wait of n cycles; dt counts the cycles between the reads.
  task automatic span(input int n);
    rd(`GT_A_CNTL, a);
    t1 = cyc;
    repeat (n) @(posedge hclk);
    rd(`GT_A_CNTL, r);
    d = r[7:0] - a[7:0];
    dt = cyc - t1;
  endtask

  task automatic load(input logic [7:0] lo, input logic [7:0] hi);
    wr(`GT_A_CTRL, 32'h0);
    wr(`GT_A_CNTH, {24'h0, hi});
    wr(`GT_A_CNTL, {24'h0, lo});
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    hwrite = 1'b0;
    htrans = 2'h0;
    hwdata = 32'h0;
    run = 1'b0;
    gate_lvl = 1'b0;
    sleep_active = 1'b0;
    capture_evt = 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rd(`GT_A_CTRL, r); chk(r, 32'h0);
    chk(hresp, 32'h0);
    rd(`GT_A_IRQC, r); chk(r, 32'h0);
    wr(`GT_A_CTRL, 32'hFF); rd(`GT_A_CTRL, r); chk(r, 32'h37);
    wr(`GT_A_CLKS, 32'hFF); rd(`GT_A_CLKS, r); chk(r, 32'h0F);
    wr(8'h40, 32'hFF); rd(8'h40, r); chk(r, 32'h0);
    $display("test registers done");
    wr(`GT_A_CLKS, 32'h1);
    load(8'hFE, 8'hFF);
    wr(`GT_A_CTRL, 32'h1);
    repeat (40) @(posedge hclk);
    rd(`GT_A_IRQC, r); chk(r, 32'h1);
    rd(`GT_A_CNTH, r); chk(r, 32'h0);
    chk(irq_req, 1'b0);
    wr(`GT_A_IRQC, 32'h0D);
    @(negedge hclk); chk(irq_req, 1'b0);
    wr(`GT_A_IRQC, 32'h1D);
    @(negedge hclk); chk(irq_req, 1'b1);
    rd(`GT_A_IRQC, r); chk(r, 32'h1D);
    wr(`GT_A_IRQC, 32'h1C);
    @(negedge hclk); chk(irq_req, 1'b0);
    $display("test overflow done");
    for (p = 0; p < 4; p++) begin
      wr(`GT_A_CLKS, 32'h2);
      load(8'h0, 8'h0);
      wr(`GT_A_CTRL, 32'h1 | (p << 4));
      span(60);
      chk(d * (1 << p) > dt - (1 << p) && d * (1 << p) < dt + (1 << p),
          1);
    end
    wr(`GT_A_CTRL, 32'h0); span(20); chk(d, 8'h0);
    wr(`GT_A_CLKS, 32'hE); wr(`GT_A_CTRL, 32'h1);
    span(20); chk(d, 8'h0);
    $display("test prescale done");
    wr(`GT_A_CTRL, 32'h2);
    wr(`GT_A_CNTH, 32'h12); wr(`GT_A_CNTL, 32'h34);
    rd(`GT_A_CNTL, r); chk(r, 32'h34);
    rd(`GT_A_CNTH, r); chk(r, 32'h12);
    $display("test wide access done");
    wr(`GT_A_CLKS, 32'h2);
    wr(`GT_A_GCTL, 32'hC0); wr(`GT_A_CTRL, 32'h1);
    repeat (8) @(posedge hclk);
    span(20); chk(d, 8'h0);
    gate_lvl <= 1'b1;
    repeat (8) @(posedge hclk);
    rd(`GT_A_GCTL, r); chk(r[2], 1'b1);
    span(20); chk(d != 8'h0, 1);
    wr(`GT_A_GCTL, 32'h80); span(20); chk(d, 8'h0);
    wr(`GT_A_GCTL, 32'h0); gate_lvl <= 1'b0;
    repeat (8) @(posedge hclk);
    wr(`GT_A_GCTL, 32'hD8); wr(`GT_A_IRQC, 32'h0);
    gate_lvl <= 1'b1;
    repeat (8) @(posedge hclk);
    gate_lvl <= 1'b0;
    repeat (8) @(posedge hclk);
    rd(`GT_A_GCTL, r); chk(r, 32'hD0);
    rd(`GT_A_IRQC, r); chk(r, 32'h2);
    wr(`GT_A_GCTL, 32'h0);
    $display("test gate done");
    wr(`GT_A_CLKS, 32'h1);
    load(8'h0, 8'h0);
    wr(`GT_A_IRQC, 32'h0); wr(`GT_A_CMP, 32'h20); wr(`GT_A_CCPM, 32'h6);
    ncmp = 0;
    wr(`GT_A_CTRL, 32'h1);
    repeat (600) @(posedge hclk);
    chk(ncmp >= 3, 1);
    rd(`GT_A_CNTL, r); chk(r <= 32'h21, 1);
    rd(`GT_A_CNTH, r); chk(r, 32'h0);
    rd(`GT_A_IRQC, r); chk(r, 32'h0);
    $display("test compare done");
    wr(`GT_A_CCPM, 32'h1); load(8'h34, 8'h12);
    @(posedge hclk); capture_evt <= 1'b1;
    @(posedge hclk); capture_evt <= 1'b0;
    rd(`GT_A_CAP, r); chk(r, 32'h1234);
    $display("test capture done");
    wr(`GT_A_CCPM, 32'h0); wr(`GT_A_CLKS, 32'h0);
    load(8'hF0, 8'hFF);
    wr(`GT_A_IRQC, 32'h0C); wr(`GT_A_CTRL, 32'h5);
    nwake = 0; run <= 1'b1; sleep_active <= 1'b1;
    repeat (300) @(posedge hclk);
    chk(nwake >= 1, 1);
    wr(`GT_A_CTRL, 32'h1); span(40); chk(d, 8'h0);
    wr(`GT_A_IRQC, 32'h20);
    @(negedge hclk); chk(secondary_oscillator_run_req, 1'b1);
    wr(`GT_A_CTRL, 32'h5); span(40); chk(d != 8'h0, 1);
    $display("test sleep done");
    wrap_up();
  end
endmodule // test_gated_16bit_timer_control
